// *** rsc_ctrl.sv ***
// Module: radio subsystem control and status register with debug bus routing
`timescale 1ns/1ps
module rsc_ctrl (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [rsc_pkg::ADDR_W-1:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   input wire logic [rsc_pkg::RSSI_W-1:0] rssi_peak_in,
   input wire logic [rsc_pkg::RSSI_W-1:0] rssi_avg_in,
   output logic [rsc_pkg::RSSI_W-1:0] rssi_out,
   input wire logic slow_clock_in,
   input wire logic slow_timer_reset_in,
   input wire logic deep_sleep_req_in,
   input wire logic radio_powered_in,
   input wire logic sleep_exit_interrupt_in,
   input wire logic core_on_master_clock_in,
   input wire logic wake_event_in,
   output logic lowpower_wakeup_interrupt_out,
   output logic [5:0] master_clock_mhz_out,
   output logic powerdown_permitted_out,
   input wire logic em_access_error_in,
   output logic em_error_irq_out,
   input wire logic [7:0] bb_diag0_in,
   input wire logic [7:0] bb_diag1_in,
   input wire logic [7:0] bb_diag2_in,
   input wire logic [7:0] radio_diag0_in,
   input wire logic [7:0] radio_diag1_in,
   output logic [7:0] port0_pins_out,
   output logic [3:0] port1_pins_out
);
   import rsc_pkg::*;

   // ************************************************
   // State
   // ************************************************
   typedef enum logic [1:0] {
      PD_IDLE,
      PD_WAIT,
      PD_ALLOWED
   } rsc_pd_e;

   typedef struct packed {
      logic [31:0] ctrl;
      logic wake_pend;
      logic wake_ack_arm;
      logic edge_seen;
      logic err_stat;
      rsc_pd_e pd;
      logic [31:0] rdata;
      logic [RSSI_W-1:0] rssi;
      logic [7:0] p0;
      logic [3:0] p1;
   } rsc_ctrl_s;

   rsc_ctrl_s st_reg;
   rsc_ctrl_s st_next;

   logic [3:0] async_vec;
   logic [3:0] sync_level;
   logic [3:0] sync_rise;
   logic slow_tick;
   logic timer_held;
   logic hit;
   logic [7:0] dbg;
   logic [31:0] rd_word;

   function automatic logic [7:0] rsc_rev8(input logic [7:0] v);
      logic [7:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[i] = v[7-i];
      end
      return r;
   endfunction : rsc_rev8

   // ************************************************
   // Slow-domain crossing
   // ************************************************
   assign async_vec = {deep_sleep_req_in, slow_timer_reset_in,
      wake_event_in, slow_clock_in};

   rsc_sync #(.W(4)) u_sync (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .async_in(async_vec),
      .stable_out(sync_level),
      .rise_out(sync_rise)
   );

   assign slow_tick = sync_rise[0];
   assign timer_held = sync_level[2];
   assign hit = (addr_in == RSC_CTRL_ADDR);

   // ************************************************
   // Debug source and read word
   // ************************************************
   always_comb begin
      unique case (st_reg.ctrl[SRC_HI:SRC_LO])
         SRC_MIXED: dbg = {bb_diag2_in[7:5], bb_diag1_in[4:3],
            bb_diag0_in[2:0]};
         SRC_WAKE: dbg = {bb_diag2_in[7:5], bb_diag1_in[4:3],
            bb_diag0_in[2], st_reg.wake_pend, sync_level[3]};
         SRC_RADIO0: dbg = radio_diag0_in;
         SRC_RADIO1: dbg = radio_diag1_in;
      endcase
   end

   always_comb begin
      rd_word = st_reg.ctrl & RSC_RW_MASK;
      rd_word[WAKE_STAT_BIT] = st_reg.wake_pend;
      rd_word[PWRDN_BIT] = (st_reg.pd == PD_ALLOWED);
      rd_word[EDGE_BIT] = st_reg.edge_seen;
      rd_word[CLKSRC_BIT] = core_on_master_clock_in;
      rd_word[ERRSTAT_BIT] = st_reg.err_stat;
   end

   // ************************************************
   // Next state
   // ************************************************
   always_comb begin
      st_next = st_reg;
      st_next.rdata = '0;
      if (rd_in && hit) begin
         st_next.rdata = rd_word;
      end
      if (wr_in && hit) begin
         // Keep-zero fields stored as written, never used
         st_next.ctrl = wdata_in & RSC_RW_MASK;
         if (!wdata_in[EDGE_BIT]) begin
            st_next.edge_seen = 1'b0;
         end
         if (wdata_in[ERRACK_BIT]) begin
            st_next.err_stat = 1'b0;
         end
      end
      // Hardware sets win over software clears
      if (slow_tick && !timer_held) begin
         st_next.edge_seen = 1'b1;
      end
      if (em_access_error_in) begin
         st_next.err_stat = 1'b1;
      end
      // Wakeup pending; first slow tick after power-up arms, second acknowledges
      if (sync_rise[1]) begin
         st_next.wake_pend = 1'b1;
         st_next.wake_ack_arm = 1'b0;
      end else if (st_reg.wake_pend && radio_powered_in) begin
         if (st_reg.wake_ack_arm && slow_tick) begin
            st_next.wake_pend = 1'b0;
            st_next.wake_ack_arm = 1'b0;
         end else if (slow_tick) begin
            st_next.wake_ack_arm = 1'b1;
         end
      end
      // Power-down permission sequence paced by slow clock
      unique case (st_reg.pd)
         PD_IDLE: begin
            if (sync_level[3] && slow_tick) begin
               st_next.pd = PD_WAIT;
            end
         end
         PD_WAIT: begin
            if (sleep_exit_interrupt_in) begin
               st_next.pd = PD_IDLE;
            end else if (slow_tick) begin
               st_next.pd = PD_ALLOWED;
            end
         end
         PD_ALLOWED: begin
            if (sleep_exit_interrupt_in) begin
               st_next.pd = PD_IDLE;
            end
         end
         // Unused code falls back to idle rather than lock up
         default: begin
            st_next.pd = PD_IDLE;
         end
      endcase
      st_next.rssi = st_reg.ctrl[RSSI_SEL_BIT] ? rssi_avg_in
         : rssi_peak_in;
      if (st_reg.ctrl[REVERSE_BIT]) begin
         st_next.p0 = rsc_rev8(dbg);
      end else begin
         st_next.p0 = dbg;
      end
      st_next.p1 = st_next.p0[3:0];
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
         st_reg.ctrl <= RSC_CTRL_RESET;
         st_reg.pd <= PD_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************
   assign rdata_out = st_reg.rdata;
   assign rssi_out = st_reg.rssi;
   assign lowpower_wakeup_interrupt_out = st_reg.wake_pend;
   assign master_clock_mhz_out = st_reg.ctrl[MHZ_HI:MHZ_LO];
   assign powerdown_permitted_out = (st_reg.pd == PD_ALLOWED);
   assign em_error_irq_out = st_reg.err_stat & st_reg.ctrl[ERRMSK_BIT];
   assign port0_pins_out = st_reg.p0;
   assign port1_pins_out = st_reg.p1;

   // ************************************************
   // Checks
   // ************************************************
   // Registered outputs lag reset release by one edge
   rssi_route_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      $past(rst_n_in) |-> rssi_out == ($past(st_reg.ctrl[RSSI_SEL_BIT]) ?
         $past(rssi_avg_in) : $past(rssi_peak_in)))
      else $error("rssi source wrong");

   wake_read_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      rd_in && hit |=>
         rdata_out[WAKE_STAT_BIT] == $past(st_reg.wake_pend))
      else $error("wake status not mirrored");

   wake_ack_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      $fell(lowpower_wakeup_interrupt_out) |->
         $past(radio_powered_in) && $past(slow_tick))
      else $error("wakeup acknowledged too early");

   mhz_field_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      wr_in && hit |=>
         master_clock_mhz_out == $past(wdata_in[MHZ_HI:MHZ_LO]))
      else $error("mhz field not stored");

   pd_set_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      $rose(powerdown_permitted_out) |-> $past(st_reg.pd == PD_WAIT))
      else $error("powerdown set out of sequence");

   pd_clear_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      sleep_exit_interrupt_in |=> !powerdown_permitted_out)
      else $error("powerdown not cleared");

   edge_set_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      slow_tick && !timer_held |=> st_reg.edge_seen)
      else $error("edge flag not set");

   clk_src_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      rd_in && hit |=>
         rdata_out[CLKSRC_BIT] == $past(core_on_master_clock_in))
      else $error("clock source misreported");

   pin_map_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      $past(rst_n_in) |->
         port0_pins_out[0] == ($past(st_reg.ctrl[REVERSE_BIT]) ?
         $past(dbg[7]) : $past(dbg[0])) &&
         port1_pins_out[3] == ($past(st_reg.ctrl[REVERSE_BIT]) ?
         $past(dbg[4]) : $past(dbg[3])))
      else $error("debug pin order wrong");

   reserved_zero_a: assert property (
      @(posedge clock_in) disable iff (!rst_n_in)
      rd_in |=> rdata_out[31:22] == '0 && rdata_out[16:15] == '0)
      else $error("reserved bits nonzero");
endmodule : rsc_ctrl

// *** rsc_pkg.sv ***
// Package: register map, field positions and constants of the radio control block
package rsc_pkg;
   localparam int ADDR_W = 32;
   localparam logic [31:0] RSC_CTRL_ADDR = 32'h40000200;
   localparam logic [31:0] RSC_CTRL_RESET = 32'h00000004;
   localparam logic [31:0] RSC_RW_MASK = 32'h002e7e3c;
   localparam int RSSI_SEL_BIT = 21;
   localparam int WAKE_STAT_BIT = 20;
   localparam int KEEP_HI = 19;
   localparam int KEEP_LO = 17;
   localparam int MHZ_HI = 14;
   localparam int MHZ_LO = 9;
   localparam int PWRDN_BIT = 8;
   localparam int EDGE_BIT = 7;
   localparam int CLKSRC_BIT = 6;
   localparam int REVERSE_BIT = 5;
   localparam int SRC_HI = 4;
   localparam int SRC_LO = 3;
   localparam int ERRMSK_BIT = 2;
   localparam int ERRACK_BIT = 1;
   localparam int ERRSTAT_BIT = 0;
   localparam int RSSI_W = 8;
   localparam logic [1:0] SRC_MIXED = 2'h0;
   localparam logic [1:0] SRC_WAKE = 2'h1;
   localparam logic [1:0] SRC_RADIO0 = 2'h2;
   localparam logic [1:0] SRC_RADIO1 = 2'h3;
   localparam int SYNC_LEN = 3;
endpackage : rsc_pkg

// *** rsc_sync.sv ***
// Module: three-stage synchroniser for a vector of slow-domain levels
`timescale 1ns/1ps
module rsc_sync #(
   parameter int W = 4
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] stable_out,
   output logic [W-1:0] rise_out
);
   import rsc_pkg::*;

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] level;
      logic [W-1:0] rise;
   } rsc_sync_s;

   rsc_sync_s st_reg;
   rsc_sync_s st_next;

   always_comb begin
      st_next = st_reg;
      st_next.s1 = async_in;
      st_next.s2 = st_reg.s1;
      st_next.s3 = st_reg.s2;
      st_next.rise = '0;
      for (int i = 0; i < W; i++) begin
         // A change counts only once stages two and three agree
         if (st_reg.s2[i] == st_reg.s3[i]) begin
            st_next.rise[i] = st_reg.s2[i] & ~st_reg.level[i];
            st_next.level[i] = st_reg.s2[i];
         end
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign stable_out = st_reg.level;
   assign rise_out = st_reg.rise;
endmodule : rsc_sync

// *** radio_subsystem_control_tb_top.sv ***
// Testbench: register, status and debug pin checks for the control block
`timescale 1ns/1ps
module radio_subsystem_control_tb_top;
   import rsc_pkg::*;
   // ************************************************
   // Stimulus signals
   // ************************************************
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [ADDR_W-1:0] addr_in = '0;
   logic [31:0] wdata_in = '0;
   logic wr_in = 1'b0, rd_in = 1'b0;
   logic [31:0] rdata_out;
   logic [7:0] peak = 8'h5a, avg = 8'ha5, rssi_out;
   logic slow_clk = 1'b0, tmr_rst = 1'b1, sleep_req = 1'b0, powered = 1'b0;
   logic slp_exit = 1'b0, on_master = 1'b0, wake = 1'b0, em_err = 1'b0;
   logic wake_irq, pwrdn;
   logic [5:0] mhz;
   logic [7:0] bb0 = 8'h96, bb1 = 8'h3c, bb2 = 8'he1;
   logic [7:0] rad0 = 8'h5b, rad1 = 8'hc4, p0, src;
   logic [3:0] p1;
   logic [31:0] d;
   int fail_count = 0;
   int n_tests = 0;
   int k;
   always #25 clock_in = ~clock_in;
   rsc_ctrl u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
      .rdata_out(rdata_out), .rssi_peak_in(peak), .rssi_avg_in(avg),
      .rssi_out(rssi_out), .slow_clock_in(slow_clk),
      .slow_timer_reset_in(tmr_rst), .deep_sleep_req_in(sleep_req),
      .radio_powered_in(powered), .sleep_exit_interrupt_in(slp_exit),
      .core_on_master_clock_in(on_master), .wake_event_in(wake),
      .lowpower_wakeup_interrupt_out(wake_irq),
      .master_clock_mhz_out(mhz), .powerdown_permitted_out(pwrdn),
      .em_access_error_in(em_err), .em_error_irq_out(),
      .bb_diag0_in(bb0), .bb_diag1_in(bb1), .bb_diag2_in(bb2),
      .radio_diag0_in(rad0), .radio_diag1_in(rad1),
      .port0_pins_out(p0), .port1_pins_out(p1));
   // ************************************************
   // Bus and check tasks
   // ************************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
         fail_count++;
      end
   endtask : chk
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge clock_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= v;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask : wr
   // Data stands only in the cycle after the read edge
   task automatic rd(input logic [31:0] a);
      @(posedge clock_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask : rd
   task automatic waitc(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : waitc
   // Slow pulse wide enough for the three-flop synchroniser
   task automatic tick();
      @(posedge clock_in);
      slow_clk <= 1'b1;
      waitc(6);
      slow_clk <= 1'b0;
      waitc(6);
   endtask : tick
   function automatic logic [7:0] rev(input logic [7:0] v);
      for (int i = 0; i < 8; i++) rev[i] = v[7-i];
   endfunction : rev
   task automatic end_of_test();
      $display("fail_count=%0d n_tests=%0d", fail_count, n_tests);
      if (fail_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test
   initial begin
      #2000000;
      fail_count++;
      end_of_test();
   end
   // ************************************************
   // Main sequence
   // ************************************************
   initial begin
      repeat (4) @(posedge clock_in);
      rst_n_in <= 1'b1;
      rd(RSC_CTRL_ADDR);
      chk(d, RSC_CTRL_RESET);
      wr(RSC_CTRL_ADDR, 32'hffffffff);
      rd(RSC_CTRL_ADDR);
      chk(d, RSC_RW_MASK);
      chk({26'h0, mhz}, 32'h3f);
      wr(32'h40000204, 32'h0);
      rd(32'h40000204);
      chk(d, 32'h0);
      rd(RSC_CTRL_ADDR);
      chk(d, RSC_RW_MASK);
      wr(RSC_CTRL_ADDR, 32'h00002004);
      waitc(1);
      chk({26'h0, mhz}, 32'h10);
      wr(RSC_CTRL_ADDR, 32'h00001004);
      waitc(2);
      chk({26'h0, mhz}, 32'h8);
      chk({24'h0, rssi_out}, 32'h5a);
      wr(RSC_CTRL_ADDR, 32'h00201004);
      waitc(2);
      chk({24'h0, rssi_out}, 32'ha5);
      on_master <= 1'b1;
      rd(RSC_CTRL_ADDR);
      chk({31'h0, d[CLKSRC_BIT]}, 32'h1);
      on_master <= 1'b0;
      rd(RSC_CTRL_ADDR);
      chk({31'h0, d[CLKSRC_BIT]}, 32'h0);
      // Timer held in reset: edges must be ignored
      tick();
      rd(RSC_CTRL_ADDR);
      chk({31'h0, d[EDGE_BIT]}, 32'h0);
      tmr_rst <= 1'b0;
      tick();
      rd(RSC_CTRL_ADDR);
      chk({31'h0, d[EDGE_BIT]}, 32'h1);
      wr(RSC_CTRL_ADDR, 32'h00001084);
      rd(RSC_CTRL_ADDR);
      chk({31'h0, d[EDGE_BIT]}, 32'h1);
      wr(RSC_CTRL_ADDR, 32'h00001004);
      rd(RSC_CTRL_ADDR);
      chk({31'h0, d[EDGE_BIT]}, 32'h0);
      wake <= 1'b1;
      waitc(6);
      chk({31'h0, wake_irq}, 32'h1);
      rd(RSC_CTRL_ADDR);
      chk({31'h0, d[WAKE_STAT_BIT]}, 32'h1);
      // Pending holds until powered plus two slow ticks
      tick();
      rd(RSC_CTRL_ADDR);
      chk({31'h0, d[WAKE_STAT_BIT]}, 32'h1);
      powered <= 1'b1;
      // Handler polls until the status reads clear, bounded
      k = 0;
      while (d[WAKE_STAT_BIT] && k < 8) begin
         tick();
         rd(RSC_CTRL_ADDR);
         k++;
      end
      chk(k, 2);
      chk({31'h0, d[WAKE_STAT_BIT]}, 32'h0);
      chk({31'h0, wake_irq}, 32'h0);
      wake <= 1'b0;
      sleep_req <= 1'b1;
      tick();
      chk({31'h0, pwrdn}, 32'h0);
      tick();
      rd(RSC_CTRL_ADDR);
      chk({31'h0, d[PWRDN_BIT]}, 32'h1);
      chk({31'h0, pwrdn}, 32'h1);
      sleep_req <= 1'b0;
      @(posedge clock_in);
      slp_exit <= 1'b1;
      @(posedge clock_in);
      slp_exit <= 1'b0;
      waitc(2);
      chk({31'h0, pwrdn}, 32'h0);
      rd(RSC_CTRL_ADDR);
      chk({31'h0, d[PWRDN_BIT]}, 32'h0);
      // Deep sleep level shows in bit 0 of the wakeup source
      sleep_req <= 1'b1;
      // Every source with both pin orders
      for (int s = 0; s < 4; s++) begin
         for (int r = 0; r < 2; r++) begin
            wr(RSC_CTRL_ADDR, 32'h00001004 | (r << 5) | (s << 3));
            waitc(3);
            case (s)
               0: src = {bb2[7:5], bb1[4:3], bb0[2:0]};
               1: src = {bb2[7:5], bb1[4:3], bb0[2], 2'b01};
               2: src = rad0;
               default: src = rad1;
            endcase
            if (r == 1) src = rev(src);
            chk({24'h0, p0}, {24'h0, src});
            chk({28'h0, p1}, {28'h0, src[3:0]});
         end
      end
      // Mid-run reset restores the reset word and pin source
      rst_n_in <= 1'b0;
      waitc(4);
      rst_n_in <= 1'b1;
      rd(RSC_CTRL_ADDR);
      chk(d, RSC_CTRL_RESET);
      chk({31'h0, pwrdn}, 32'h0);
      chk({24'h0, p0}, {24'h0, bb2[7:5], bb1[4:3], bb0[2:0]});
      end_of_test();
   end
endmodule : radio_subsystem_control_tb_top
